// file: hdl/lrd_pkg.sv
// constants, types and bus map of the link request stream decoder
// assumes one 250 MHz core clock and an APB master for the control registers
//
// Summary of operation
// - stream length fixed by request type
// - start bit one, stop bit zero
// - type code follows start bit, four bits
// - type code sent most significant first
// - type 0001 arbitrates at next idle
// - types 0010/0011 asynchronous even/odd phase
// - type 0100 asynchronous current fairness interval
// - types 0110/0111 isochronous even/odd period
// - type 1000 arbitrates for cycle start
// - type 1010 returns register via status
// - type 1011 writes addressed register
// - types 1100/1101 isochronous phase notifications
// - type 1110 cycle start due notification
// - bus request format, speed, stop positions
// - stop bit optional when bit six zero
// - format flag one requests beta format
// - speed codes: valid, reserved, invalid
// - invalid speed arbitrates, sends null packet
// - read request address bits five-eight
// - write request address, data, stop positions
// - request bits tied to link clock
// - illegal stream reports interface error status
package lrd_pkg;

    // stream lengths in bits
    localparam logic [4:0] LEN_BUS = 5'h0B;
    localparam logic [4:0] LEN_READ = 5'h0A;
    localparam logic [4:0] LEN_WRITE = 5'h12;
    localparam logic [4:0] LEN_NOTE = 5'h06;
    // last bit index after which a bus request may end early
    localparam logic [4:0] IDX_BUS_EARLY = 5'h09;
    // field positions inside a stream
    localparam logic [4:0] IDX_TYPE_LAST = 5'h04;
    localparam logic [4:0] IDX_FMT = 5'h05;
    localparam logic [4:0] IDX_SPEED_FIRST = 5'h06;
    localparam logic [4:0] IDX_SPEED_LAST = 5'h09;
    localparam logic [4:0] IDX_ADDR_FIRST = 5'h05;
    localparam logic [4:0] IDX_ADDR_LAST = 5'h08;
    localparam logic [4:0] IDX_DATA_FIRST = 5'h09;
    localparam logic [4:0] IDX_DATA_LAST = 5'h10;

    // request type codes
    localparam logic [3:0] RT_IMMED = 4'h1;
    localparam logic [3:0] RT_NEXT_EVEN = 4'h2;
    localparam logic [3:0] RT_NEXT_ODD = 4'h3;
    localparam logic [3:0] RT_CURRENT = 4'h4;
    localparam logic [3:0] RT_ISO_EVEN = 4'h6;
    localparam logic [3:0] RT_ISO_ODD = 4'h7;
    localparam logic [3:0] RT_CYC_START = 4'h8;
    localparam logic [3:0] RT_REG_READ = 4'hA;
    localparam logic [3:0] RT_REG_WRITE = 4'hB;
    localparam logic [3:0] RT_PHASE_EVEN = 4'hC;
    localparam logic [3:0] RT_PHASE_ODD = 4'hD;
    localparam logic [3:0] RT_CYC_DUE = 4'hE;

    // speed codes
    localparam logic [3:0] SPD_S100 = 4'h0;
    localparam logic [3:0] SPD_S200 = 4'h2;
    localparam logic [3:0] SPD_S400 = 4'h4;
    localparam logic [3:0] SPD_S800 = 4'h6;
    localparam logic [3:0] SPD_LAST_DEFINED = 4'h6;

    // register map, byte addresses
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_REQ_COUNT = 12'h008;
    localparam logic [11:0] OFS_ERR_COUNT = 12'h00C;
    localparam logic [11:0] OFS_REGS_BASE = 12'h040;
    localparam logic [11:0] OFS_REGS_MASK = 12'hFC0;
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int STATUS_BUSY_BIT = 8;
    localparam logic CTRL_ENABLE_RESET = 1'b1;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b01,
        RX_RECV = 2'b10
    } lrd_rx_state_t;

    typedef struct packed {
        logic valid;
        logic [3:0] kind;
        logic immediate;
        logic beta_format;
        logic [3:0] speed;
        logic null_packet;
    } lrd_arb_req_t;

    typedef struct packed {
        logic valid;
        logic solicited_reg;
        logic iface_error;
        logic [3:0] addr;
        logic [7:0] data;
    } lrd_status_t;

    typedef struct packed {
        logic iso_phase_even;
        logic iso_phase_odd;
        logic cycle_start_due;
    } lrd_note_t;

endpackage : lrd_pkg

// file: hdl/lrd_decoder.sv
// serial link request decoder with its internal register file and apb slave
// assumes link clock and request line arrive asynchronously; link drives on its rising edge
`timescale 1ns/1ps
module lrd_decoder #(
    parameter int REG_COUNT = 16
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic link_returned_clock,
    input wire logic link_request_line,
    output lrd_pkg::lrd_arb_req_t arb_req,
    output lrd_pkg::lrd_status_t status_out,
    output lrd_pkg::lrd_note_t note_out,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    import lrd_pkg::*;

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (REG_COUNT != 16) begin : g_bad_count
        $error("register count must be 16 for a four bit address");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] clk_sync;
        logic [1:0] line_sync;
        logic clk_prev;
        lrd_rx_state_t rx;
        logic [4:0] bit_idx;
        logic [4:0] len;
        logic [3:0] rtype;
        logic fmt;
        logic [3:0] speed;
        logic [3:0] addr;
        logic [7:0] wdata;
        logic [15:0][7:0] phy_regs;
        logic enable;
        logic [3:0] last_type;
        logic [15:0] req_count;
        logic [15:0] err_count;
        lrd_arb_req_t arb;
        lrd_status_t stat;
        lrd_note_t note;
        logic [31:0] rdata;
        logic rerr;
    } lrd_state_t;

    lrd_state_t s;
    lrd_state_t next_s;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic is_bus_type(input logic [3:0] t);
        case (t)
            RT_IMMED, RT_NEXT_EVEN, RT_NEXT_ODD, RT_CURRENT: is_bus_type = 1'b1;
            RT_ISO_EVEN, RT_ISO_ODD, RT_CYC_START: is_bus_type = 1'b1;
            default: is_bus_type = 1'b0;
        endcase
    endfunction : is_bus_type

    function automatic logic [4:0] len_of(input logic [3:0] t);
        if (is_bus_type(t)) begin
            len_of = LEN_BUS;
        end else if (t == RT_REG_READ) begin
            len_of = LEN_READ;
        end else if (t == RT_REG_WRITE) begin
            len_of = LEN_WRITE;
        end else begin
            // notifications and reserved codes
            len_of = LEN_NOTE;
        end
    endfunction : len_of

    function automatic logic is_reserved(input logic [3:0] t);
        is_reserved = !is_bus_type(t) && (t != RT_REG_READ) && (t != RT_REG_WRITE)
            && (t != RT_PHASE_EVEN) && (t != RT_PHASE_ODD) && (t != RT_CYC_DUE);
    endfunction : is_reserved

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic bit_strobe;
    logic bit_val;
    logic done;
    logic stop_ok;
    logic [4:0] idx_plus;
    logic apb_setup;
    logic apb_access;
    logic [31:0] rd_mux;
    logic rd_hit;

    always_comb begin
        next_s = s;
        // two stage synchronisers; only stage two is looked at
        next_s.clk_sync = {s.clk_sync[0], link_returned_clock};
        next_s.line_sync = {s.line_sync[0], link_request_line};
        next_s.clk_prev = s.clk_sync[1];
        // sample on falling link edge, mid bit
        bit_strobe = s.clk_prev & ~s.clk_sync[1];
        bit_val = s.line_sync[1];
        idx_plus = s.bit_idx + 5'h01;
        done = 1'b0;
        stop_ok = 1'b0;
        // event outputs are one cycle pulses
        next_s.arb.valid = 1'b0;
        next_s.stat.valid = 1'b0;
        next_s.stat.solicited_reg = 1'b0;
        next_s.stat.iface_error = 1'b0;
        next_s.note = '0;

        case (s.rx)
            RX_IDLE: begin
                // a low line between streams is idle or an omitted stop bit
                if (bit_strobe && bit_val && s.enable) begin
                    next_s.rx = RX_RECV;
                    next_s.bit_idx = 5'h01;
                    next_s.rtype = '0;
                    next_s.len = LEN_NOTE;
                end
            end
            RX_RECV: begin
                if (bit_strobe) begin
                    next_s.bit_idx = idx_plus;
                    if (s.bit_idx <= IDX_TYPE_LAST) begin
                        next_s.rtype = {s.rtype[2:0], bit_val};
                        if (s.bit_idx == IDX_TYPE_LAST) begin
                            next_s.len = len_of({s.rtype[2:0], bit_val});
                        end
                    end
                    if (s.bit_idx == IDX_FMT) begin
                        next_s.fmt = bit_val;
                    end
                    if (s.bit_idx >= IDX_SPEED_FIRST && s.bit_idx <= IDX_SPEED_LAST) begin
                        next_s.speed = {s.speed[2:0], bit_val};
                    end
                    if (s.bit_idx >= IDX_ADDR_FIRST && s.bit_idx <= IDX_ADDR_LAST) begin
                        next_s.addr = {s.addr[2:0], bit_val};
                    end
                    if (s.bit_idx >= IDX_DATA_FIRST && s.bit_idx <= IDX_DATA_LAST) begin
                        next_s.wdata = {s.wdata[6:0], bit_val};
                    end
                    if (s.bit_idx == s.len - 5'h01) begin
                        done = 1'b1;
                        stop_ok = !bit_val;
                    end else if (is_bus_type(s.rtype) && s.bit_idx == IDX_BUS_EARLY
                                 && !s.speed[2]) begin
                        // speed msb, stream bit six, was zero
                        done = 1'b1;
                        stop_ok = 1'b1;
                    end
                end
                if (done) begin
                    next_s.rx = RX_IDLE;
                    next_s.last_type = s.rtype;
                    next_s.req_count = s.req_count + 16'h0001;
                    if (!stop_ok || is_reserved(s.rtype)) begin
                        next_s.err_count = s.err_count + 16'h0001;
                        next_s.stat.valid = 1'b1;
                        next_s.stat.iface_error = 1'b1;
                    end else if (is_bus_type(s.rtype)) begin
                        // types 0001..0100, 0110..1000 to arbitration
                        next_s.arb.valid = 1'b1;
                        next_s.arb.kind = s.rtype;
                        next_s.arb.immediate = (s.rtype == RT_IMMED);
                        next_s.arb.beta_format = s.fmt;
                        // field complete only after this bit, early end included
                        next_s.arb.speed = next_s.speed;
                        // invalid speed still arbitrates, with null payload
                        next_s.arb.null_packet = next_s.speed > SPD_LAST_DEFINED;
                    end else if (s.rtype == RT_REG_READ) begin
                        next_s.stat.valid = 1'b1;
                        next_s.stat.solicited_reg = 1'b1;
                        next_s.stat.addr = s.addr;
                        next_s.stat.data = s.phy_regs[s.addr];
                    end else if (s.rtype == RT_REG_WRITE) begin
                        // data bits end before the stop bit
                        next_s.phy_regs[s.addr] = s.wdata;
                    end else begin
                        next_s.note.iso_phase_even = (s.rtype == RT_PHASE_EVEN);
                        next_s.note.iso_phase_odd = (s.rtype == RT_PHASE_ODD);
                        next_s.note.cycle_start_due = (s.rtype == RT_CYC_DUE);
                    end
                end
            end
            default: begin
                next_s.rx = RX_IDLE;
            end
        endcase

        // apb: read data and error captured in setup, answered in access
        apb_setup = psel & ~penable;
        apb_access = psel & penable;
        rd_hit = 1'b1;
        rd_mux = '0;
        if ((paddr & OFS_REGS_MASK) == OFS_REGS_BASE) begin
            rd_mux = {24'h000000, s.phy_regs[paddr[5:2]]};
        end else begin
            case (paddr)
                OFS_CTRL: rd_mux = {31'h00000000, s.enable};
                OFS_STATUS: rd_mux = {23'h000000, s.rx == RX_RECV, 4'h0, s.last_type};
                OFS_REQ_COUNT: rd_mux = {16'h0000, s.req_count};
                OFS_ERR_COUNT: rd_mux = {16'h0000, s.err_count};
                default: rd_hit = 1'b0;
            endcase
        end
        if (apb_setup) begin
            next_s.rdata = pwrite ? 32'h00000000 : rd_mux;
            next_s.rerr = !rd_hit || paddr[1:0] != 2'h0 || (pwrite && paddr != OFS_CTRL);
        end
        if (apb_access && pwrite && paddr == OFS_CTRL && pstrb[0]) begin
            next_s.enable = pwdata[CTRL_ENABLE_BIT];
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            s <= '0;
            s.rx <= RX_IDLE;
            s.len <= LEN_NOTE;
            s.enable <= CTRL_ENABLE_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign arb_req = s.arb;
    assign status_out = s.stat;
    assign note_out = s.note;
    assign prdata = s.rdata;
    assign pslverr = s.rerr & psel & penable;
    assign pready = psel & penable;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_start_bit_high: assert property (
        @(posedge clk) disable iff (reset)
        (s.rx == RX_IDLE ##1 s.rx == RX_RECV) |-> $past(s.line_sync[1]) && $past(s.enable)
    ) else $error("capture began without a high start bit");

    a_bus_len: assert property (
        @(posedge clk) disable iff (reset)
        s.arb.valid |-> $past(s.bit_idx) == LEN_BUS - 5'h01
            || ($past(s.bit_idx) == IDX_BUS_EARLY && !s.arb.speed[3])
    ) else $error("bus request ended at wrong bit");

    a_read_len: assert property (
        @(posedge clk) disable iff (reset)
        (s.stat.valid && s.stat.solicited_reg) |-> $past(s.bit_idx) == LEN_READ - 5'h01
    ) else $error("read request ended at wrong bit");

    a_write_len: assert property (
        @(posedge clk) disable iff (reset)
        (s.phy_regs != $past(s.phy_regs)) |-> $past(s.bit_idx) == LEN_WRITE - 5'h01
            && $past(s.rtype) == RT_REG_WRITE
    ) else $error("register changed outside a write request");

    a_no_reserved_arb: assert property (
        @(posedge clk) disable iff (reset)
        s.arb.valid |-> !is_reserved(s.arb.kind) && is_bus_type(s.arb.kind)
    ) else $error("arbitration for a non bus type");

    a_null_invalid: assert property (
        @(posedge clk) disable iff (reset)
        s.arb.valid |-> (s.arb.null_packet == (s.arb.speed > SPD_LAST_DEFINED))
            && s.arb.speed == s.speed
    ) else $error("null packet flag disagrees with speed");

    a_read_data: assert property (
        @(posedge clk) disable iff (reset)
        (s.stat.valid && s.stat.solicited_reg) |-> s.stat.addr == s.addr
            && s.stat.data == $past(s.phy_regs[s.addr])
    ) else $error("read status carries wrong data");

    a_note_len: assert property (
        @(posedge clk) disable iff (reset)
        (s.note != '0) |-> $past(s.bit_idx) == LEN_NOTE - 5'h01 ##1 s.note == '0
    ) else $error("notification at wrong bit or too long");

    a_error_stop: assert property (
        @(posedge clk) disable iff (reset)
        (s.rx == RX_RECV && s.bit_idx == s.len - 5'h01 && bit_strobe && bit_val)
            |=> s.stat.valid && s.stat.iface_error
    ) else $error("bad stop bit not reported");

    a_immediate: assert property (
        @(posedge clk) disable iff (reset)
        s.arb.valid |-> (s.arb.immediate == (s.arb.kind == RT_IMMED)) ##1 !s.arb.valid
    ) else $error("immediate flag wrong or pulse too long");

    a_status_pulse: assert property (
        @(posedge clk) disable iff (reset)
        s.stat.valid |=> !s.stat.valid
    ) else $error("status pulse longer than one cycle");

    a_len_decode: assert property (
        @(posedge clk) disable iff (reset)
        (s.rx == RX_RECV && s.bit_idx > IDX_TYPE_LAST) |-> s.len == len_of(s.rtype)
    ) else $error("stream length disagrees with type");

    a_idx_bound: assert property (
        @(posedge clk) disable iff (reset)
        (s.rx == RX_RECV) |-> s.bit_idx <= LEN_WRITE - 5'h01
    ) else $error("bit index beyond longest stream");

    a_reserved_error: assert property (
        @(posedge clk) disable iff (reset)
        (done && is_reserved(s.rtype))
            |=> s.stat.valid && s.stat.iface_error && !s.arb.valid && s.note == '0
    ) else $error("reserved type not reported as error");

    a_write_data: assert property (
        @(posedge clk) disable iff (reset)
        (done && stop_ok && s.rtype == RT_REG_WRITE) |=> s.phy_regs[s.addr] == s.wdata
    ) else $error("write request data not stored");

    a_early_stop: assert property (
        @(posedge clk) disable iff (reset)
        (s.rx == RX_RECV && bit_strobe && is_bus_type(s.rtype)
            && s.bit_idx == IDX_BUS_EARLY && !s.speed[2])
            |=> s.rx == RX_IDLE && s.arb.valid
    ) else $error("short bus request not accepted");

    a_capture_start: assert property (
        @(posedge clk) disable iff (reset)
        (s.rx == RX_IDLE ##1 s.rx == RX_RECV) |-> s.bit_idx == 5'h01
    ) else $error("capture did not start at bit one");

    a_disabled_idle: assert property (
        @(posedge clk) disable iff (reset)
        (s.rx == RX_IDLE && !s.enable) |=> s.rx == RX_IDLE
    ) else $error("capture began while disabled");

    a_ctrl_write: assert property (
        @(posedge clk) disable iff (reset)
        (psel && penable && pwrite && paddr == OFS_CTRL && pstrb[0])
            |=> s.enable == $past(pwdata[CTRL_ENABLE_BIT])
    ) else $error("enable bit write lost");

    a_one_event: assert property (
        @(posedge clk) disable iff (reset)
        $onehot0({s.arb.valid, s.stat.valid, s.note != '0})
    ) else $error("one stream raised two events");

    a_note_onehot: assert property (
        @(posedge clk) disable iff (reset)
        (s.note != '0) |-> $onehot(s.note)
    ) else $error("more than one notification flag");

    a_beta_flag: assert property (
        @(posedge clk) disable iff (reset)
        s.arb.valid |-> s.arb.beta_format == s.fmt
    ) else $error("format flag not passed on");

    a_arb_kind: assert property (
        @(posedge clk) disable iff (reset)
        s.arb.valid |-> s.arb.kind == s.last_type && s.arb.kind == s.rtype
    ) else $error("arbitration kind disagrees with type");

endmodule : lrd_decoder

// file: tb/lrd_link_model.sv
// link controller model that drives the serial request line
// assumes the core clock paces it; one link period is 20 core cycles (80 ns)
`timescale 1ns/1ps
module lrd_link_model (
    input wire logic clk,
    output logic link_returned_clock,
    output logic link_request_line
);
    // ------------------------------
    // frame sender
    // ------------------------------
    initial begin
        link_returned_clock = 1'b0;
        link_request_line = 1'b0;
    end

    // bits go out from bits[n-1] down to bits[0]; clock stands still between frames
    task automatic send(input logic [17:0] bits, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge clk);
            link_returned_clock <= 1'b1;
            link_request_line <= bits[i];
            repeat (10) @(posedge clk);
            link_returned_clock <= 1'b0;
            repeat (9) @(posedge clk);
        end
        link_request_line <= 1'b0;
    endtask : send
endmodule : lrd_link_model

// file: tb/link_request_stream_decoder_tb.sv
// self-checking bench for the link request decoder
// assumes the link model file and the design package are compiled first
`timescale 1ns/1ps
module link_request_stream_decoder_tb;
    import lrd_pkg::*;
    logic clk;
    logic reset;
    logic link_returned_clock;
    logic link_request_line;
    lrd_arb_req_t arb_req;
    lrd_status_t status_out;
    lrd_note_t note_out;
    logic psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    int err_total = 0;
    int samples_checked = 0;
    int cycles = 0;
    int arb_n, st_n;
    lrd_arb_req_t arb_last;
    lrd_status_t st_last;
    lrd_note_t note_acc;
    logic [3:0] bt [7] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8};
    logic [3:0] bs [7] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h8, 4'h5, 4'hF};
    logic [3:0] rv [4] = '{4'h0, 4'h5, 4'h9, 4'hF};

    lrd_decoder dut (.clk(clk), .reset(reset), .link_returned_clock(link_returned_clock),
        .link_request_line(link_request_line), .arb_req(arb_req), .status_out(status_out),
        .note_out(note_out), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    lrd_link_model lm (.clk(clk), .link_returned_clock(link_returned_clock),
        .link_request_line(link_request_line));

    // ------------------------------
    // clock, event capture, timeout
    // ------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (arb_req.valid === 1'b1) begin
            arb_last = arb_req;
            arb_n++;
        end
        if (status_out.valid === 1'b1) begin
            st_last = status_out;
            st_n++;
        end
        note_acc = note_acc | note_out;
        if (cycles == 20000) begin
            err_total++;
            close_out();
        end
    end

    // ------------------------------
    // tasks
    // ------------------------------
    task automatic close_out();
        if (err_total == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic go(input logic [17:0] b, input int n);
        arb_n = 0;
        st_n = 0;
        note_acc = '0;
        lm.send(b, n);
        repeat (6) @(posedge clk);
    endtask : go

    // ------------------------------
    // tests
    // ------------------------------
    initial begin
        reset = 1'b1;
        {psel, penable, pwrite} = 3'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hF;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk(rd, 32'h1);
        for (int i = 0; i < 7; i++) begin
            if (bs[i][3]) begin
                go({7'h0, 1'b1, bt[i], i[0], bs[i], 1'b0}, 11);
            end else begin
                go({8'h0, 1'b1, bt[i], i[0], bs[i]}, 10);
            end
            chk(arb_n + st_n, 1);
            chk(32'({1'b1, bt[i], bt[i] == 4'h1, i[0], bs[i], bs[i] > 4'h6}),
                32'(arb_last));
        end
        lm.send({1'b1, 4'hB, 4'h5, 8'hA5, 1'b0}, 18);
        go({8'h0, 1'b1, 4'hA, 4'h5, 1'b0}, 10);
        chk(arb_n + st_n, 1);
        chk(32'(st_last), 32'({3'b110, 4'h5, 8'hA5}));
        apb(1'b0, OFS_REGS_BASE + 12'h014, 32'h0);
        chk(rd, 32'hA5);
        for (int i = 0; i < 3; i++) begin
            go({12'h0, 1'b1, 4'hC + 4'(i), 1'b0}, 6);
            chk(32'(note_acc), 32'(3'b100 >> i));
            chk(arb_n + st_n, 0);
        end
        for (int i = 0; i < 5; i++) begin
            go({12'h0, 1'b1, (i < 4) ? rv[i] : 4'hC, i == 4}, 6);
            chk(arb_n + st_n, 1);
            chk(32'({st_last.valid, st_last.solicited_reg, st_last.iface_error}), 32'h5);
            chk(32'(note_acc), 32'h0);
        end
        apb(1'b1, OFS_CTRL, 32'h0);
        go({12'h0, 1'b1, 4'hC, 1'b0}, 6);
        chk(32'(note_acc) + arb_n + st_n, 32'h0);
        apb(1'b1, OFS_CTRL, 32'h1);
        apb(1'b0, 12'h010, 32'h0);
        chk(32'(er), 32'h1);
        apb(1'b1, OFS_STATUS, 32'h0);
        chk(32'(er), 32'h1);
        apb(1'b0, OFS_ERR_COUNT, 32'h0);
        chk(rd, 32'h5);
        apb(1'b0, OFS_REQ_COUNT, 32'h0);
        chk(rd, 32'h11);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rd, 32'h0000000C);
        close_out();
    end
endmodule : link_request_stream_decoder_tb
